// [rtl/clkd_top.sv]
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module clkd_top #(
	parameter logic [8:0] P_CTRL_NV = clkd_pkg::CTRL_RST,
	parameter logic [9:0] P_DIV_NV = clkd_pkg::DIV_RST,
	parameter logic [9:0] P_DAC_NV = clkd_pkg::DAC_RST,
	parameter logic [4:0] P_RANGE_NV = clkd_pkg::RANGE_RST
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ref_ctl_in, // pin, asynchronous
	input wire logic i_main_ctl_in, // pin, asynchronous
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic o_ref_clk_out,
	output logic o_ref_clk_oe_n, // low while driving
	output logic o_main_clk_out,
	output logic o_main_clk_oe_n, // low while driving
	output logic o_osc_run, // low stops the oscillator
	output logic [9:0] o_dac_code,
	output logic [4:0] o_range_ofs
);

	// ============================================================
	// configuration registers
	logic [8:0] ctrl_reg; // routing and mode bits
	logic [9:0] div_reg; // main divider code
	logic [9:0] dac_reg; // oscillator frequency code
	logic [4:0] range_reg; // oscillator range offset

	// mapped address check, shared by both bus directions
	function automatic logic addr_hit(input logic [7:0] a);
		return a == clkd_pkg::OFS_CTRL || a == clkd_pkg::OFS_DIV ||
			a == clkd_pkg::OFS_DAC || a == clkd_pkg::OFS_RANGE ||
			a == clkd_pkg::OFS_STATUS;
	endfunction : addr_hit

	// ============================================================
	// control input synchronisers
	logic [1:0] ref_sync_reg; // stage 0 is read only by stage 1
	logic [1:0] main_sync_reg;
	logic ref_ctl; // synchronised level
	logic main_ctl;

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ref_sync_reg <= 2'b00;
			main_sync_reg <= 2'b00;
		end else begin
			ref_sync_reg <= {ref_sync_reg[0], i_ref_ctl_in};
			main_sync_reg <= {main_sync_reg[0], i_main_ctl_in};
		end
	end
	assign ref_ctl = ref_sync_reg[1];
	assign main_ctl = main_sync_reg[1];

	// ============================================================
	// control input roles
	logic ref_en, ref_sel, ref_pdn, main_pdn;
	logic ref_pd, main_pd; // power-down requests
	logic ref_want, main_want; // output should drive
	logic ref_psc_sel; // reference mux picks the prescaler
	logic ref_go, main_go; // next value of the output enables

	assign ref_en = ctrl_reg[clkd_pkg::CB_REF_EN];
	assign ref_sel = ctrl_reg[clkd_pkg::CB_REF_SEL];
	assign ref_pdn = ctrl_reg[clkd_pkg::CB_REF_PDN];
	assign main_pdn = ctrl_reg[clkd_pkg::CB_MAIN_PDN];
	assign ref_go = ref_want & ~(ref_pd | main_pd);
	assign main_go = main_want & ~(ref_pd | main_pd);

	always_comb begin
		// with neither enable nor select, the pin is a pure shutdown
		ref_pd = (ref_pdn | (~ref_en & ~ref_sel)) & ref_ctl;
		main_pd = main_pdn & main_ctl;
		// enable or power-down role: high pin floats the output
		ref_want = (ref_en | ref_pdn) ? ~ref_ctl : ref_sel;
		main_want = ~main_ctl;
		// select-only role: the pin drives the mux
		if (~ref_en & ref_sel & ~ref_pdn) begin
			ref_psc_sel = ref_ctl;
		end else begin
			ref_psc_sel = ref_sel;
		end
	end

	// ============================================================
	// oscillator run and output enables
	logic osc_run_reg; // all counters are cleared while low
	logic ref_on_reg; // reference output driving
	logic main_on_reg; // main output driving

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			osc_run_reg <= 1'b1;
			ref_on_reg <= 1'b0;
			main_on_reg <= 1'b0;
		end else begin
			osc_run_reg <= ~(ref_pd | main_pd);
			// enabling restarts the path from phase zero
			ref_on_reg <= ref_go;
			main_on_reg <= main_go;
		end
	end

	// ============================================================
	// reference path: prescaler and select mux
	logic [2:0] ref_cnt_reg; // prescaler phase
	logic [2:0] ref_mask; // terminal count of the chosen route
	logic ref_tick; // one cycle per reference half period
	logic ref_out_reg;

	// mask zero gives a tick every cycle, the direct route
	assign ref_mask = ref_psc_sel ? clkd_pkg::psc_mask(
		ctrl_reg[clkd_pkg::CB_REF_MODE +: 2]) : 3'h0;
	// at or past the mask, so a faster mode never waits for a wrap
	assign ref_tick = ref_on_reg & osc_run_reg & (ref_cnt_reg >= ref_mask);

	always_ff @(posedge i_core_clk) begin
		if (i_rst || !ref_on_reg) begin
			ref_cnt_reg <= 3'h0;
			ref_out_reg <= 1'b0;
		end else if (osc_run_reg) begin
			ref_cnt_reg <= ref_tick ? 3'h0 : ref_cnt_reg + 3'h1;
			// the pin goes low in the same edge as its enable drops
			if (!ref_go) begin
				ref_out_reg <= 1'b0;
			end else if (ref_tick) begin
				ref_out_reg <= ~ref_out_reg;
			end
		end
	end

	// ============================================================
	// main path: prescaler, divider and bypass
	logic [2:0] main_cnt_reg;
	logic [2:0] main_mask;
	logic main_psc_tick; // prescaler output rate
	logic div_tick; // divider output rate
	logic main_tick;
	logic main_out_reg;

	assign main_mask = clkd_pkg::psc_mask(
		ctrl_reg[clkd_pkg::CB_MAIN_MODE +: 2]);
	assign main_psc_tick = main_on_reg & osc_run_reg &
		(main_cnt_reg >= main_mask);
	assign main_tick = ctrl_reg[clkd_pkg::CB_BYPASS] ?
		main_psc_tick : div_tick;

	clkd_div #(
		.W(10)
	) u_div (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_clr(~main_on_reg),
		.i_tick(main_psc_tick),
		.i_ratio(div_reg),
		.o_tick(div_tick)
	);

	always_ff @(posedge i_core_clk) begin
		if (i_rst || !main_on_reg) begin
			main_cnt_reg <= 3'h0;
			main_out_reg <= 1'b0;
		end else if (osc_run_reg) begin
			main_cnt_reg <= main_psc_tick ? 3'h0 : main_cnt_reg + 3'h1;
			// the pin goes low in the same edge as its enable drops
			if (!main_go) begin
				main_out_reg <= 1'b0;
			end else if (main_tick) begin
				main_out_reg <= ~main_out_reg;
			end
		end
	end

	assign o_ref_clk_out = ref_out_reg;
	assign o_ref_clk_oe_n = ~ref_on_reg;
	assign o_main_clk_out = main_out_reg;
	assign o_main_clk_oe_n = ~main_on_reg;
	assign o_osc_run = osc_run_reg;
	assign o_dac_code = dac_reg;
	assign o_range_ofs = range_reg;

	// ============================================================
	// bus slave: write address, write data, response
	logic aw_full_reg, w_full_reg; // channel captured
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic wr_go; // both halves held, write this cycle
	logic [15:0] wr_val; // strobe-merged low half word

	// no new channel is taken until the answer has left
	assign o_s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign o_s_axi_wready = ~w_full_reg & ~bvalid_reg;
	assign o_s_axi_arready = ~rvalid_reg;
	assign wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;

	// address and data may arrive in either order
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end else if (i_s_axi_awvalid && o_s_axi_awready) begin
			aw_full_reg <= 1'b1;
			aw_addr_reg <= i_s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else if (i_s_axi_wvalid && o_s_axi_wready) begin
			w_full_reg <= 1'b1;
			w_data_reg <= i_s_axi_wdata;
			w_strb_reg <= i_s_axi_wstrb;
		end else if (wr_go) begin
			w_full_reg <= 1'b0;
		end
	end

	// response one cycle after both halves are held
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= clkd_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= addr_hit(aw_addr_reg) ? clkd_pkg::RESP_OKAY :
				clkd_pkg::RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ============================================================
	// register write, byte lanes 0 and 1 only hold bits
	always_comb begin
		wr_val[7:0] = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
		wr_val[15:8] = w_strb_reg[1] ? w_data_reg[15:8] : 8'h00;
	end

	// reset stands for power-up: the store is copied in
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ctrl_reg <= P_CTRL_NV;
			div_reg <= P_DIV_NV;
			dac_reg <= P_DAC_NV;
			range_reg <= P_RANGE_NV;
		end else if (wr_go) begin
			// a lane without its strobe keeps its old bits
			if (aw_addr_reg == clkd_pkg::OFS_CTRL) begin
				ctrl_reg <= {w_strb_reg[1] ? wr_val[8] : ctrl_reg[8],
					w_strb_reg[0] ? wr_val[7:0] : ctrl_reg[7:0]};
			end
			if (aw_addr_reg == clkd_pkg::OFS_DIV) begin
				div_reg <= {w_strb_reg[1] ? wr_val[9:8] : div_reg[9:8],
					w_strb_reg[0] ? wr_val[7:0] : div_reg[7:0]};
			end
			if (aw_addr_reg == clkd_pkg::OFS_DAC) begin
				dac_reg <= {w_strb_reg[1] ? wr_val[9:8] : dac_reg[9:8],
					w_strb_reg[0] ? wr_val[7:0] : dac_reg[7:0]};
			end
			if (aw_addr_reg == clkd_pkg::OFS_RANGE && w_strb_reg[0]) begin
				range_reg <= wr_val[4:0];
			end
		end
	end

	// ============================================================
	// read channel: data one cycle after the address is taken
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= clkd_pkg::RESP_OKAY;
		end else if (i_s_axi_arvalid && o_s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= addr_hit(i_s_axi_araddr) ? clkd_pkg::RESP_OKAY :
				clkd_pkg::RESP_SLVERR;
			unique case (i_s_axi_araddr)
				clkd_pkg::OFS_CTRL: rdata_reg <= {23'h0, ctrl_reg};
				clkd_pkg::OFS_DIV: rdata_reg <= {22'h0, div_reg};
				clkd_pkg::OFS_DAC: rdata_reg <= {22'h0, dac_reg};
				clkd_pkg::OFS_RANGE: rdata_reg <= {27'h0, range_reg};
				clkd_pkg::OFS_STATUS: rdata_reg <= {26'h0, ref_psc_sel,
					main_on_reg, ref_on_reg, osc_run_reg, main_ctl, ref_ctl};
				default: rdata_reg <= 32'h0000_0000; // unmapped
			endcase
		end else if (i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;

	// ============================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	a_sync_two_ff: assert property (
		!$past(i_rst) && !$past(i_rst, 2) |->
		ref_ctl == $past(i_ref_ctl_in, 2))
		else $error("reference input not delayed by two flops");
	a_off_floats: assert property (
		!ref_on_reg |-> o_ref_clk_oe_n && !o_ref_clk_out)
		else $error("disabled reference output still driven");
	a_pd_stops_osc: assert property (
		(ref_pd || main_pd) |=> !o_osc_run && o_main_clk_oe_n)
		else $error("power-down did not stop the oscillator");
	a_main_oe_pin: assert property (
		(main_ctl && !main_pdn && !ref_pd) |=> o_main_clk_oe_n && o_osc_run)
		else $error("main enable pin role wrong");
	a_ref_first_edge: assert property (
		($rose(ref_on_reg) && ref_mask == 3'h7 && $stable(ref_mask))
		|-> !o_ref_clk_out [*8] ##1 o_ref_clk_out)
		else $error("reference first edge not after eight cycles");
	a_bypass_direct: assert property (
		(main_on_reg && o_osc_run && main_mask == 3'h0 &&
		ctrl_reg[clkd_pkg::CB_BYPASS]) [*2] |-> $changed(main_out_reg))
		else $error("bypassed main path not at master rate");
	a_write_answer: assert property (
		(aw_full_reg && w_full_reg && !bvalid_reg) |=> o_s_axi_bvalid)
		else $error("write answer not one cycle after both halves");
	a_bresp_holds: assert property (
		(o_s_axi_bvalid && !i_s_axi_bready) |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped before ready");
	a_read_answer: assert property (
		(i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid)
		else $error("read answer late");
	a_nv_load: assert property (
		$past(i_rst) |-> ctrl_reg == P_CTRL_NV && div_reg == P_DIV_NV)
		else $error("power-up settings not loaded");

	c_ref_enable: cover property ($rose(ref_on_reg));
	c_power_down: cover property ($fell(osc_run_reg));
	c_main_divided: cover property (div_tick && main_on_reg);
	c_bus_write: cover property (wr_go);

endmodule : clkd_top

// [rtl/clkd_pkg.sv]
// ============================================================
// shared constants for the dual output clock divider
package clkd_pkg;

	// ============================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // mode and routing bits
	localparam logic [7:0] OFS_DIV = 8'h04; // main divider code
	localparam logic [7:0] OFS_DAC = 8'h08; // oscillator frequency code
	localparam logic [7:0] OFS_RANGE = 8'h0c; // oscillator range offset
	localparam logic [7:0] OFS_STATUS = 8'h10; // live state, read only

	// ============================================================
	// control register field positions
	localparam int CB_REF_EN = 0; // ref_out_en_cfg
	localparam int CB_REF_SEL = 1; // ref_mux_sel_cfg
	localparam int CB_REF_PDN = 2; // ref_pwrdn_cfg
	localparam int CB_MAIN_PDN = 3; // main_pwrdn_cfg
	localparam int CB_BYPASS = 4; // divider_bypass
	localparam int CB_REF_MODE = 5; // ref_psc_mode_lo, _hi at +1
	localparam int CB_MAIN_MODE = 7; // main_psc_mode_lo, _hi at +1
	localparam int CTRL_W = 9;

	// ============================================================
	// power-up contents of the nonvolatile store
	localparam logic [8:0] CTRL_RST = 9'h003; // ref enable and select
	localparam logic [9:0] DIV_RST = 10'h000; // divide by two
	localparam logic [9:0] DAC_RST = 10'h200; // mid code
	localparam logic [4:0] RANGE_RST = 5'h10; // mid range

	// ============================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// prescaler terminal count for a two bit mode: /1 /2 /4 /8
	function automatic logic [2:0] psc_mask(input logic [1:0] mode);
		unique case (mode)
			2'b00: return 3'h0;
			2'b01: return 3'h1;
			2'b10: return 3'h3;
			2'b11: return 3'h7;
		endcase
	endfunction : psc_mask

endpackage : clkd_pkg

// [rtl/clkd_div.sv]
`timescale 1ns/10ps
// ============================================================
// programmable divider: one output tick per (code + 2) input ticks
module clkd_div #(
	parameter int W = 10
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clr, // holds the phase at zero
	input wire logic i_tick, // prescaled input rate
	input wire logic [W-1:0] i_ratio, // code, divides by code + 2
	output logic o_tick
);

	logic [W:0] cnt_reg; // input ticks seen in this period
	logic [W:0] top; // last count of the period

	// code 0 means two, so the top of the longest ratio needs W+1 bits
	assign top = {1'b0, i_ratio} + (W+1)'(1);
	// at or past the top, so a ratio cut mid-period takes effect at once
	// instead of running the counter all the way round
	assign o_tick = i_tick & (cnt_reg >= top);

	// ============================================================
	// period counter, restarted by clear so phase is repeatable
	always_ff @(posedge i_core_clk) begin
		if (i_rst || i_clr) begin
			cnt_reg <= '0;
		end else if (o_tick) begin
			cnt_reg <= '0;
		end else if (i_tick) begin
			cnt_reg <= cnt_reg + (W+1)'(1);
		end
	end

	a_div_restart: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_tick |=> (cnt_reg == '0))
		else $error("divider did not restart after its tick");

endmodule : clkd_div

// [verification/clkd_host_model.sv]
`timescale 1ns/10ps
// ============================================================
// register bus master standing in for the host processor
module clkd_host_model (
	input wire logic i_core_clk,
	output logic [7:0] o_awaddr,
	output logic o_awvalid,
	input wire logic i_awready,
	output logic [31:0] o_wdata,
	output logic [3:0] o_wstrb,
	output logic o_wvalid,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	output logic o_bready,
	output logic [7:0] o_araddr,
	output logic o_arvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic o_rready
);
	// bus idle from time zero
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
		{o_araddr, o_arvalid, o_rready} = '0;
	end

	// ============================================================
	// write: address and data offered together, each dropped when taken;
	// no cycle count assumed, the bench timeout ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge i_core_clk);
		o_awaddr <= a;
		o_awvalid <= 1'b1;
		o_wdata <= d;
		o_wstrb <= 4'hf;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		do begin
			@(posedge i_core_clk);
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'b0;
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'b0;
			end
		end while (!(i_bvalid && o_bready));
		r = i_bresp;
		o_bready <= 1'b0;
	endtask : wr

	// ============================================================
	// read: address held until taken, rready held until the answer
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge i_core_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		do begin
			@(posedge i_core_clk);
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'b0;
			end
		end while (!(i_rvalid && o_rready));
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask : rd
endmodule : clkd_host_model

// [verification/test_dual_output_clock_divider.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			$display("Error %s expected %0h seen %0h", nm, e, g); \
			n_errors++; \
		end \
	end

module test_dual_output_clock_divider;
	// ============================================================
	// clock, reset, pins and bus wires
	logic core_clk = 1'b0;
	logic rst = 1'b1; // held for 16 cycles
	logic ref_pin = 1'b0;
	logic main_pin = 1'b0;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic ref_out, ref_oe_n, main_out, main_oe_n, osc_run;
	logic [9:0] dac;
	logic [4:0] rng;
	// registers and their power-up contents
	logic [7:0] ofs [4] = '{clkd_pkg::OFS_CTRL, clkd_pkg::OFS_DIV,
		clkd_pkg::OFS_DAC, clkd_pkg::OFS_RANGE};
	logic [31:0] nv [4] = '{32'(clkd_pkg::CTRL_RST),
		32'(clkd_pkg::DIV_RST), 32'(clkd_pkg::DAC_RST),
		32'(clkd_pkg::RANGE_RST)};

	// 250 MHz
	always #2 core_clk = ~core_clk;

	clkd_top uut (.i_core_clk(core_clk), .i_rst(rst),
		.i_ref_ctl_in(ref_pin), .i_main_ctl_in(main_pin),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_ref_clk_out(ref_out),
		.o_ref_clk_oe_n(ref_oe_n), .o_main_clk_out(main_out),
		.o_main_clk_oe_n(main_oe_n), .o_osc_run(osc_run),
		.o_dac_code(dac), .o_range_ofs(rng));

	clkd_host_model host (.i_core_clk(core_clk), .o_awaddr(awaddr),
		.o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
		.o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
		.i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
		.i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
		.o_rready(rready));

	// ============================================================
	// expectations: [8:7] main mode, [6:5] ref mode, bypass, main pdn, ref pdn, sel, en
	function automatic logic [31:0] ctl(input bit en, sel, rpd, mpd, byp,
		logic [1:0] rm, mm);
		return {23'h0, mm, rm, byp, mpd, rpd, sel, en};
	endfunction : ctl

	// toggle output: period is twice the division ratio
	function automatic int ref_per(input bit sel, logic [1:0] md);
		return sel ? (2 << md) : 2;
	endfunction : ref_per

	function automatic int main_per(input bit byp, logic [1:0] md,
		logic [9:0] k);
		return byp ? (2 << md) : (2 << md) * (int'(k) + 2);
	endfunction : main_per

	// ============================================================
	// period between 2nd and 3rd rise; first rise may straddle a change
	task automatic meas(input bit m, output int p);
		logic a;
		logic b;
		int r;
		int t;
		a = 1'b1;
		r = 0;
		t = 0;
		p = 0;
		for (int i = 0; i < 8000; i++) begin
			@(posedge core_clk);
			b = m ? main_out : ref_out;
			if (!a && b) begin
				r++;
				if (r == 2) begin
					t = i;
				end
				if (r == 3) begin
					p = i - t;
					break;
				end
			end
			a = b;
		end
	endtask : meas

	// cycles from main pin enable to first main rise, random idle first
	task automatic lead(output int n);
		main_pin <= 1'b1;
		repeat (20 + $urandom % 40) @(posedge core_clk);
		main_pin <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!main_out && n < 4000);
	endtask : lead

	task final_report;
		$display("tests %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// hang guard, well above the longest divider run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			final_report();
		end
	end

	// ============================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] md;
		logic [1:0] rm;
		logic [9:0] k;
		logic [4:0] o5;
		int p;
		int q;
		void'($urandom(72));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		// stored contents come back after power-up
		for (int i = 0; i < 4; i++) begin
			host.rd(ofs[i], d, r);
			`CHK("nv reg", nv[i], d);
		end
		// live state: mux on prescaler, both outputs on, oscillator running
		host.rd(clkd_pkg::OFS_STATUS, d, r);
		`CHK("status", 32'h0000_003c, d);
		`CHK("dac out", clkd_pkg::DAC_RST, dac);
		`CHK("ref oe_n", 1'b0, ref_oe_n);
		`CHK("main oe_n", 1'b0, main_oe_n);
		// frequency code and range, full-scale corner first
		for (int i = 0; i < 4; i++) begin
			k = (i == 0) ? 10'h3ff : 10'($urandom);
			o5 = 5'($urandom);
			host.wr(clkd_pkg::OFS_DAC, {22'h0, k}, r);
			host.wr(clkd_pkg::OFS_RANGE, {27'h0, o5}, r);
			`CHK("dac code", k, dac);
			`CHK("range", o5, rng);
		end
		`CHK("range resp", clkd_pkg::RESP_OKAY, r);
		// unmapped place: refused, nothing read
		host.wr(8'h14, 32'hffff_ffff, r);
		`CHK("wr resp", clkd_pkg::RESP_SLVERR, r);
		host.rd(8'h14, d, r);
		`CHK("rd resp", clkd_pkg::RESP_SLVERR, r);
		`CHK("rd data", 32'h0000_0000, d);
		// reference prescaler, every mode, then direct route
		for (int m = 0; m < 4; m++) begin
			host.wr(clkd_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0, 2'(m), 0), r);
			meas(1'b0, p);
			`CHK("ref period", ref_per(1'b1, 2'(m)), p);
		end
		host.wr(clkd_pkg::OFS_CTRL, ctl(1, 0, 0, 0, 0, 2'd3, 0), r);
		meas(1'b0, p);
		`CHK("ref direct", ref_per(1'b0, 2'd3), p);
		// select-only role: pin high picks the prescaled clock
		host.wr(clkd_pkg::OFS_CTRL, ctl(0, 1, 0, 0, 0, 2'd3, 0), r);
		ref_pin <= 1'b1;
		meas(1'b0, p);
		`CHK("ref mux", ref_per(1'b1, 2'd3), p);
		ref_pin <= 1'b0;
		// main path: each mode, long divider corner, bypass
		for (int i = 0; i < 6; i++) begin
			md = (i < 4) ? 2'(i) : 2'b00;
			k = (i == 4) ? 10'h3ff : 10'($urandom % 16);
			rm = 2'($urandom);
			host.wr(clkd_pkg::OFS_DIV, {22'h0, k}, r);
			host.wr(clkd_pkg::OFS_CTRL, ctl(1, 1, 0, 0, i == 5, rm, md), r);
			host.rd(clkd_pkg::OFS_DIV, d, r);
			`CHK("div reg", {22'h0, k}, d);
			meas(1'b1, p);
			`CHK("main period", main_per(i == 5, md, k), p);
			meas(1'b0, q);
			`CHK("ref beside", ref_per(1'b1, rm), q);
		end
		// pins as output enables: high floats the pin, low drives it
		// slowest reference mode: first edge after enable is eight cycles out
		host.wr(clkd_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0, 2'd3, 0), r);
		ref_pin <= 1'b1;
		main_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK("ref off", 1'b1, ref_oe_n);
		`CHK("main off", 1'b1, main_oe_n);
		`CHK("main low", 1'b0, main_out);
		`CHK("no pdn", 1'b1, osc_run);
		ref_pin <= 1'b0;
		main_pin <= 1'b0;
		// settings stay put until the reference has made its first edge
		repeat (16) @(posedge core_clk);
		`CHK("ref on", 1'b0, ref_oe_n);
		`CHK("main on", 1'b0, main_oe_n);
		// power-down: either armed pin stops the oscillator
		for (int c = 0; c < 16; c++) begin
			host.wr(clkd_pkg::OFS_CTRL, ctl(1, 1, c[0], c[1], 0, 0, 0), r);
			ref_pin <= c[2];
			main_pin <= c[3];
			repeat (4) @(posedge core_clk);
			`CHK("osc run", ~((c[0] & c[2]) | (c[1] & c[3])), osc_run);
		end
		ref_pin <= 1'b0;
		main_pin <= 1'b0;
		// enable to first edge is the same every time
		host.wr(clkd_pkg::OFS_DIV, 32'h0000_0003, r);
		host.wr(clkd_pkg::OFS_CTRL, ctl(1, 1, 0, 0, 0, 0, 2'd1), r);
		lead(p);
		lead(q);
		`CHK("enable lead", p, q);
		final_report();
	end
endmodule : test_dual_output_clock_divider
